// ==== rtl/cbo_config_regs.sv ====
// serial-bus register bank steering the gate of output 8 and the swing and edge rate of nine clock outputs
`timescale 1ns/10ps
`default_nettype none
module cbo_config_regs (
  // system clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial bus link, clock and open-drain data
  input wire logic smb_scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // seven-bit slave address strap
  input wire logic [6:0] slave_addr,
  // per-output enable pins, active low
  input wire logic [8:0] out_en_n,
  // output control
  output logic [8:0] out_run,
  output logic [1:0] swing_code,
  output logic [8:0] edge_fast
);

  logic [1:0] lrst_ff;
  logic link_rst_n;
  logic sda_hi_ff;
  logic [6:0] addr_ff;
  cbo_pkg::cbo_state_t state_ff;
  logic [2:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] index_ff;
  logic [7:0] remain_ff;
  logic [7:0] tx_ff;
  logic rd_ff;
  logic oe_ff;
  logic gate8_ff;
  logic [1:0] swing_ff;
  logic [7:0] edge_low_ff;
  logic edge8_ff;
  logic cfg_tgl_ff;
  logic bit_in;
  logic [7:0] byte_in;
  logic start_seen_ff;
  logic stop_seen_ff;
  logic wr_en;
  logic [7:0] rd_byte;

  // reset reaches the link side only while the bus clock toggles
  always_ff @(negedge smb_scl) begin
    lrst_ff <= {lrst_ff[0], reset_n};
  end
  assign link_rst_n = lrst_ff[1];

  // data is stable while the clock is high, so sample it on the rising edge
  always_ff @(posedge smb_scl) begin
    if (!link_rst_n) begin
      sda_hi_ff <= 1'b1;
    end else begin
      sda_hi_ff <= sda_in;
    end
  end

  // strap is caught while reset is held
  always_ff @(negedge smb_scl) begin
    if (!link_rst_n) begin
      addr_ff <= slave_addr;
    end
  end

  // data edges while the clock is high mark start and stop; clock-edge sampling alone would
  // miss a start that follows a stop in one high phase. both flags clear when the clock falls
  always_ff @(negedge sda_in or negedge smb_scl) begin
    if (!smb_scl) start_seen_ff <= 1'b0;
    else start_seen_ff <= 1'b1;
  end
  always_ff @(posedge sda_in or negedge smb_scl) begin
    if (!smb_scl) stop_seen_ff <= 1'b0;
    else stop_seen_ff <= 1'b1;
  end
  assign bit_in = sda_hi_ff;
  assign byte_in = {shift_ff[6:0], bit_in};

  assign wr_en = !start_seen_ff && !stop_seen_ff && state_ff == cbo_pkg::S_WDATA &&
                 bitcnt_ff == cbo_pkg::LAST_BIT && remain_ff != cbo_pkg::RST_BYTE;

  always_comb begin
    rd_byte = cbo_pkg::UNMAPPED_VALUE;
    unique case (index_ff)
      cbo_pkg::IDX_GATE_SWING: begin
        rd_byte = cbo_pkg::GATE_SWING_FIXED;
        rd_byte[cbo_pkg::GATE8_BIT] = gate8_ff;
        rd_byte[1:0] = swing_ff;
      end
      cbo_pkg::IDX_EDGE_LOW: rd_byte = edge_low_ff;
      cbo_pkg::IDX_EDGE_HIGH: begin
        rd_byte = cbo_pkg::EDGE_HIGH_FIXED;
        rd_byte[cbo_pkg::EDGE8_BIT] = edge8_ff;
      end
      cbo_pkg::IDX_RSVD_ONES: rd_byte = cbo_pkg::RSVD_ONES_VALUE;
      cbo_pkg::IDX_REV_MAKER: rd_byte = {cbo_pkg::SILICON_REVISION_CODE, cbo_pkg::MAKER_CODE};
      default: rd_byte = cbo_pkg::UNMAPPED_VALUE;
    endcase
  end

  // protocol engine, moves and drives on the falling edge
  always_ff @(negedge smb_scl) begin
    if (!link_rst_n) begin
      state_ff <= cbo_pkg::S_IDLE;
      bitcnt_ff <= cbo_pkg::FIRST_BIT;
      shift_ff <= cbo_pkg::RST_BYTE;
      index_ff <= cbo_pkg::RST_BYTE;
      remain_ff <= cbo_pkg::RST_BYTE;
      tx_ff <= cbo_pkg::RST_BYTE;
      rd_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (start_seen_ff) begin
      state_ff <= cbo_pkg::S_ADDR;
      bitcnt_ff <= cbo_pkg::FIRST_BIT;
      oe_ff <= 1'b0;
    end else if (stop_seen_ff) begin
      state_ff <= cbo_pkg::S_IDLE;
      oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        cbo_pkg::S_IDLE, cbo_pkg::S_IGNORE: begin
          oe_ff <= 1'b0;
        end
        cbo_pkg::S_ADDR, cbo_pkg::S_INDEX, cbo_pkg::S_COUNT, cbo_pkg::S_WDATA: begin
          shift_ff <= byte_in;
          bitcnt_ff <= bitcnt_ff + 3'h1;
          if (bitcnt_ff == cbo_pkg::LAST_BIT) begin
            oe_ff <= 1'b1;
            unique case (state_ff)
              cbo_pkg::S_ADDR: begin
                if (byte_in[7:1] == addr_ff) begin
                  rd_ff <= byte_in[0];
                  state_ff <= cbo_pkg::S_ADDR_ACK;
                end else begin
                  oe_ff <= 1'b0;
                  state_ff <= cbo_pkg::S_IGNORE;
                end
              end
              cbo_pkg::S_INDEX: begin
                index_ff <= byte_in;
                state_ff <= cbo_pkg::S_INDEX_ACK;
              end
              cbo_pkg::S_COUNT: begin
                remain_ff <= byte_in;
                state_ff <= cbo_pkg::S_COUNT_ACK;
              end
              default: begin
                if (wr_en) begin
                  index_ff <= index_ff + 8'h01;
                  remain_ff <= remain_ff - 8'h01;
                end
                state_ff <= cbo_pkg::S_WDATA_ACK;
              end
            endcase
          end
        end
        cbo_pkg::S_ADDR_ACK: begin
          bitcnt_ff <= cbo_pkg::FIRST_BIT;
          if (rd_ff) begin
            tx_ff <= cbo_pkg::READ_COUNT;
            oe_ff <= ~cbo_pkg::READ_COUNT[7];
            state_ff <= cbo_pkg::S_RDATA;
          end else begin
            oe_ff <= 1'b0;
            state_ff <= cbo_pkg::S_INDEX;
          end
        end
        cbo_pkg::S_INDEX_ACK: begin
          oe_ff <= 1'b0;
          state_ff <= cbo_pkg::S_COUNT;
        end
        cbo_pkg::S_COUNT_ACK, cbo_pkg::S_WDATA_ACK: begin
          oe_ff <= 1'b0;
          state_ff <= cbo_pkg::S_WDATA;
        end
        cbo_pkg::S_RDATA: begin
          bitcnt_ff <= bitcnt_ff + 3'h1;
          if (bitcnt_ff == cbo_pkg::LAST_BIT) begin
            oe_ff <= 1'b0;
            state_ff <= cbo_pkg::S_RACK;
          end else begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            oe_ff <= ~tx_ff[6];
          end
        end
        cbo_pkg::S_RACK: begin
          bitcnt_ff <= cbo_pkg::FIRST_BIT;
          if (!bit_in) begin
            tx_ff <= rd_byte;
            oe_ff <= ~rd_byte[7];
            index_ff <= index_ff + 8'h01;
            state_ff <= cbo_pkg::S_RDATA;
          end else begin
            oe_ff <= 1'b0;
            state_ff <= cbo_pkg::S_IGNORE;
          end
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;

  // register storage, written as the last data bit arrives
  always_ff @(negedge smb_scl) begin
    if (!link_rst_n) begin
      gate8_ff <= cbo_pkg::RST_GATE8;
      swing_ff <= cbo_pkg::RST_SWING;
      edge_low_ff <= cbo_pkg::RST_EDGE_LOW;
      edge8_ff <= cbo_pkg::RST_EDGE8;
      cfg_tgl_ff <= 1'b0;
    end else if (wr_en) begin
      cfg_tgl_ff <= ~cfg_tgl_ff;
      unique case (index_ff)
        cbo_pkg::IDX_GATE_SWING: begin
          gate8_ff <= byte_in[cbo_pkg::GATE8_BIT];
          swing_ff <= byte_in[1:0];
        end
        cbo_pkg::IDX_EDGE_LOW: begin
          edge_low_ff <= byte_in;
        end
        cbo_pkg::IDX_EDGE_HIGH: begin
          edge8_ff <= byte_in[cbo_pkg::EDGE8_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  logic tgl_sync;
  logic tgl_seen_ff;
  logic [8:0] en_n_sync;
  logic gate8_sh_ff;
  logic [1:0] swing_sh_ff;
  logic [8:0] edge_sh_ff;
  logic [8:0] run_ff;

  cbo_sync #(.W(1), .RST(1'b0)) u_tgl_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(cfg_tgl_ff),
    .q(tgl_sync)
  );

  cbo_sync #(.W(9), .RST(cbo_pkg::RST_PINS_N)) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(out_en_n),
    .q(en_n_sync)
  );

  // register words are quiet for a whole byte after a toggle, far longer than the crossing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tgl_seen_ff <= 1'b0;
      gate8_sh_ff <= cbo_pkg::RST_GATE8;
      swing_sh_ff <= cbo_pkg::RST_SWING;
      edge_sh_ff <= {cbo_pkg::RST_EDGE8, cbo_pkg::RST_EDGE_LOW};
    end else begin
      tgl_seen_ff <= tgl_sync;
      if (tgl_sync != tgl_seen_ff) begin
        gate8_sh_ff <= gate8_ff;
        swing_sh_ff <= swing_ff;
        edge_sh_ff <= {edge8_ff, edge_low_ff};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_ff <= 9'h000;
    end else begin
      run_ff <= ~en_n_sync & {gate8_sh_ff, 8'hFF};
    end
  end

  assign out_run = run_ff;
  assign swing_code = swing_sh_ff;
  assign edge_fast = edge_sh_ff;

endmodule
`default_nettype wire

// ==== rtl/cbo_pkg.sv ====
// constants, register map and state type for the output configuration register bank
package cbo_pkg;

  // register indices
  localparam logic [7:0] IDX_GATE_SWING = 8'h01;
  localparam logic [7:0] IDX_EDGE_LOW = 8'h02;
  localparam logic [7:0] IDX_EDGE_HIGH = 8'h03;
  localparam logic [7:0] IDX_RSVD_ONES = 8'h04;
  localparam logic [7:0] IDX_REV_MAKER = 8'h05;

  // field positions
  localparam int GATE8_BIT = 5;
  localparam int EDGE8_BIT = 0;

  // values after reset
  localparam logic RST_GATE8 = 1'b1;
  localparam logic [1:0] RST_SWING = 2'h2;
  localparam logic [7:0] RST_EDGE_LOW = 8'hFF;
  localparam logic RST_EDGE8 = 1'b1;

  // fixed read values of reserved bits
  localparam logic [7:0] GATE_SWING_FIXED = 8'h0C;
  localparam logic [7:0] EDGE_HIGH_FIXED = 8'hC6;
  localparam logic [7:0] RSVD_ONES_VALUE = 8'hFF;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

  // count byte returned first on every read
  localparam logic [7:0] READ_COUNT = 8'h08;

  // identity nibbles, values are arbitrary
  localparam logic [3:0] SILICON_REVISION_CODE = 4'h5;
  localparam logic [3:0] MAKER_CODE = 4'hA;

  // bit counting, reset values of link state and of the enable pin synchroniser
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [8:0] RST_PINS_N = 9'h1FF;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_INDEX,
    S_INDEX_ACK,
    S_COUNT,
    S_COUNT_ACK,
    S_WDATA,
    S_WDATA_ACK,
    S_RDATA,
    S_RACK,
    S_IGNORE
  } cbo_state_t;

endpackage

// ==== rtl/cbo_sync.sv ====
// three-stage synchroniser whose output follows once the last two stages agree
`timescale 1ns/10ps
`default_nettype none
module cbo_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // per-bit agreement filters a stage caught mid-transition
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_ff <= RST;
    end else begin
      q_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
    end
  end

  assign q = q_ff;

endmodule
`default_nettype wire

// ==== tb/cbo_config_regs_chk.sv ====
// assertions watching the ports of the output configuration register bank
`timescale 1ns/10ps
`default_nettype none
module cbo_config_regs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link
  input wire logic smb_scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [6:0] slave_addr,
  // outputs
  input wire logic [8:0] out_en_n,
  input wire logic [8:0] out_run,
  input wire logic [1:0] swing_code,
  input wire logic [8:0] edge_fast
);
  logic scl_q_ff;
  logic [4:0] since_fall_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk) begin
    scl_q_ff <= smb_scl;
  end
  // saturating count of clk cycles since the link clock fell
  always_ff @(posedge clk) begin
    if (scl_q_ff && !smb_scl) since_fall_ff <= 5'h00;
    else if (since_fall_ff != 5'h1F) since_fall_ff <= since_fall_ff + 5'h01;
  end
  AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
    else $error("data output not held low");
  AST_OE_ON_FALL: assert property ($changed(sda_oe) |-> $fell(smb_scl))
    else $error("data enable moved away from a falling link clock");
  AST_OE_HOLDS: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*8])
    else $error("data enable bit too short");
  AST_RESET_DEFAULTS: assert property (disable iff (1'b0)
    !reset_n |=> (swing_code == 2'h2 && edge_fast == 9'h1FF && out_run == 9'h000))
    else $error("reset values wrong");
  AST_PIN_OFF: assert property ($rose(out_en_n[0]) |-> ##[1:8] !out_run[0])
    else $error("output 0 kept running with pin high");
  AST_PIN_ON: assert property ($fell(out_en_n[0]) |-> ##[3:8] out_run[0])
    else $error("output 0 not started by pin");
  AST_RUN8_CAUSE: assert property ($rose(out_run[8]) |-> $past(!out_en_n[8], 3))
    else $error("output 8 started with pin high");
  AST_CFG_AFTER_FALL: assert property
    (($changed(swing_code) || $changed(edge_fast)) |-> since_fall_ff < 5'h0C)
    else $error("configuration changed without link traffic");
  cover property ($rose(sda_oe));
  cover property ($changed(swing_code));
  cover property ($fell(out_run[8]));
endmodule
bind cbo_config_regs cbo_config_regs_chk cbo_config_regs_chk_inst (.clk(clk),
  .reset_n(reset_n), .smb_scl(smb_scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .slave_addr(slave_addr), .out_en_n(out_en_n), .out_run(out_run),
  .swing_code(swing_code), .edge_fast(edge_fast));
`default_nettype wire

// ==== tb/cbo_host_model.sv ====
// serial bus host issuing indexed block transfers
`timescale 1ns/10ps
`default_nettype none
module cbo_host_model (
  // link clock and open-drain data
  output var logic scl,
  output var logic pull,
  input wire logic line
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // data released, so no frame edge is seen
  task automatic pulses(input int n);
    repeat (n) begin
      #62 scl = 1'b0;
      #63 scl = 1'b1;
    end
  endtask
  task automatic start();
    pull = 1'b0;
    #31 scl = 1'b1;
    #31 pull = 1'b1;
    #31 scl = 1'b0;
    #32;
  endtask
  // stop, clock then stands still high
  task automatic stop();
    pull = 1'b1;
    #31 scl = 1'b1;
    #31 pull = 1'b0;
    #63;
  endtask
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    pull = !b;
    #31 scl = 1'b1;
    #31 r = line;
    #31 scl = 1'b0;
    #32;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ackbit, output logic [7:0] q,
      output logic ack9);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ackbit, ack9);
  endtask
endmodule
`default_nettype wire

// ==== tb/test_cbo_config_regs.sv ====
// testbench driving block transfers into the register bank
`timescale 1ns/10ps
`default_nettype none
module test_cbo_config_regs;
  localparam logic [6:0] ADDR = 7'h6B;
  localparam logic [7:0] ID = {cbo_pkg::SILICON_REVISION_CODE, cbo_pkg::MAKER_CODE};
  logic clk, reset_n, sda_out, sda_oe, scl, pull, a;
  logic [8:0] out_en_n, out_run, edge_fast;
  logic [1:0] swing_code;
  logic [7:0] q;
  wire logic line;
  int error_cnt, n_tests, cycles;
  assign line = !(pull || (sda_oe && !sda_out));
  cbo_config_regs cbo_config_regs_inst (.clk(clk), .reset_n(reset_n), .smb_scl(scl),
    .sda_in(line), .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr(ADDR),
    .out_en_n(out_en_n), .out_run(out_run), .swing_code(swing_code), .edge_fast(edge_fast));
  cbo_host_model cbo_host_model_inst (.scl(scl), .pull(pull), .line(line));
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] d);
    cbo_host_model_inst.xfer(d, 1'b1, q, a);
    chk("ack", {8'h00, a}, 9'h000);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] cnt, input int n,
      input logic [31:0] d);
    cbo_host_model_inst.start();
    send({ADDR, 1'b0});
    send(idx);
    send(cnt);
    for (int i = n - 1; i >= 0; i--) send(d[8*i +: 8]);
    cbo_host_model_inst.stop();
    // outputs settle some clk cycles after the data byte
    repeat (20) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [39:0] exp, input int n);
    cbo_host_model_inst.start();
    send({ADDR, 1'b0});
    send(idx);
    cbo_host_model_inst.start();
    send({ADDR, 1'b1});
    cbo_host_model_inst.xfer(8'hFF, 1'b0, q, a);
    chk("count", {1'b0, q}, {1'b0, cbo_pkg::READ_COUNT});
    for (int i = n - 1; i >= 0; i--) begin
      cbo_host_model_inst.xfer(8'hFF, i == 0, q, a);
      chk("reg", {1'b0, q}, {1'b0, exp[8*i +: 8]});
    end
    cbo_host_model_inst.stop();
  endtask
  initial begin
    reset_n = 1'b0;
    out_en_n = 9'h000;
    repeat (2) @(posedge clk);
    // the link side only leaves reset through falling link clock edges
    cbo_host_model_inst.pulses(4);
    @(posedge clk) reset_n <= 1'b1;
    cbo_host_model_inst.pulses(4);
    chk("swing", {7'h00, swing_code}, {7'h00, cbo_pkg::RST_SWING});
    chk("edge", edge_fast, {cbo_pkg::RST_EDGE8, cbo_pkg::RST_EDGE_LOW});
    chk("run", out_run, 9'h1FF);
    rd(cbo_pkg::IDX_GATE_SWING, {8'h2E, 8'hFF, 8'hC7, 8'hFF, ID}, 5);
    $display("test defaults done");
    wr(cbo_pkg::IDX_GATE_SWING, 8'h03, 3, 32'h005500);
    chk("swing", {7'h00, swing_code}, 9'h000);
    chk("edge", edge_fast, 9'h055);
    chk("run", out_run, 9'h0FF);
    rd(cbo_pkg::IDX_GATE_SWING, {8'h00, 8'h0C, 8'h55, 8'hC6, 8'hFF}, 4);
    $display("test gate and reserved done");
    for (int c = 0; c < 4; c++) begin
      wr(cbo_pkg::IDX_GATE_SWING, 8'h01, 1, {24'h0, 8'h20 | c[7:0]});
      chk("swing", {7'h00, swing_code}, c[8:0]);
      @(posedge clk) out_en_n <= c[0] ? 9'h1AA : 9'h055;
      repeat (12) @(posedge clk);
      chk("run", out_run, ~out_en_n);
    end
    $display("test swing codes and pins done");
    wr(cbo_pkg::IDX_EDGE_LOW, 8'h01, 2, 32'hAA00);
    wr(cbo_pkg::IDX_RSVD_ONES, 8'h02, 2, 32'h0000);
    chk("edge", edge_fast, 9'h0AA);
    rd(cbo_pkg::IDX_EDGE_LOW, {8'h00, 8'hAA, 8'hC6, 8'hFF, ID}, 4);
    $display("test count and read-only done");
    cbo_host_model_inst.start();
    cbo_host_model_inst.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
    chk("nack", {8'h00, a}, 9'h001);
    cbo_host_model_inst.stop();
    chk("swing", {7'h00, swing_code}, 9'h003);
    $display("test foreign address done");
    close_out();
  end
endmodule
`default_nettype wire
